/* logic/panel_pkg.sv */
// shared constants and types for the counter front-panel control block
package panel_pkg;
  // timebase
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned US_PER_MS     = 1000;
  localparam int unsigned FREQB_HOLD_MS = 3000;
  localparam int unsigned LAMP_HALF_MS  = 3000;
  localparam int unsigned SAVE_MS       = 60000;
  // hold-off delay store, in microseconds
  localparam logic [19:0] DLY_RST_US    = 20'h02710;
  localparam logic [19:0] DLY_MIN_US    = 20'h000c8;
  localparam logic [19:0] DLY_MAX_US    = 20'hc3500;
  localparam logic [19:0] DLY_STEP_US   = 20'h00064;
  // averaging
  localparam logic [6:0]  AVG_LAST      = 7'h63;
  localparam logic [39:0] AVG_DIV       = 40'h000000000a;
  // error codes
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_PH_FREQ   = 8'h01;
  localparam logic [7:0]  ERR_RANGE     = 8'h02;
  localparam logic [7:0]  ERR_OVF       = 8'h03;
  localparam logic [7:0]  ERR_NUM_ENTRY = 8'h04;
  localparam logic [7:0]  ERR_REM_PROG  = 8'h05;
  localparam logic [7:0]  ERR_PH_FAST   = 8'h06;
  localparam logic [7:0]  ERR_SELFTEST  = 8'h50;
  // register byte offsets
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_DELAY     = 4'h4;
  localparam logic [3:0]  REG_NULL      = 4'h8;
  localparam logic [3:0]  REG_AVG       = 4'hc;
  localparam int unsigned SYNC_W        = 12;

  typedef enum logic [2:0] {F_FREQA, F_PERA, F_TI, F_TOTAB, F_PHASE, F_RATIO, F_CHECK, F_TOTA} func_e;
  typedef enum logic [1:0] {M_MEAS, M_EDIT, M_LAMP} mode_e;
  typedef enum logic [1:0] {D_MEAS, D_NULL, D_DELAY} disp_e;

  typedef struct packed {
    logic up;
    logic down;
    logic restart;
    logic dly;
    logic avg;
    logic recall;
    logic rnull;
    logic stby;
  } keys_s;

  typedef struct packed {
    logic [31:0] reading;
    logic        start_trig;
    logic        stop_trig;
    logic        done;
    logic        range_err;
    logic        overflow;
    logic        phase_unequal;
    logic        phase_fast;
    logic        check_fail;
  } eng_s;

  typedef struct packed {
    logic delay_led;
    logic avg_led;
    logic gate_led;
    logic lamp_on;
    logic lamp_test;
    logic chan_b;
    logic standby;
  } ind_s;
endpackage

/* logic/key_sync.sv */
// three-stage input synchroniser; a level is taken once stages two and three agree
`timescale 1ns/1ps
module key_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // pins and settled levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } sync_s;

  sync_s        s;
  sync_s        n;
  logic [W-1:0] agree;

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.lv[i];
  end

  always_comb begin
    n    = s;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.lv = agree;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.lv;
endmodule

/* logic/counter_panel_control.sv */
// front-panel control: hold-off delay, averaging, frequency B, lamp test, errors, battery save
`timescale 1ns/1ps
module counter_panel_control
  import panel_pkg::*;
#(
  parameter int unsigned HOLD_MS = FREQB_HOLD_MS,
  parameter int unsigned LAMP_MS = LAMP_HALF_MS,
  parameter int unsigned IDLE_MS = SAVE_MS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // front-panel pins
  input  wire keys_s       key_pin,
  input  wire logic [2:0]  func_pin,
  input  wire logic        batt_save_pin,
  // measurement engine
  input  wire eng_s        eng,
  output logic             stop_trig_out,
  // indicators and display
  output ind_s             ind,
  output disp_e            disp_src,
  output logic [31:0]      disp_val,
  output logic [7:0]       err_code
);
  typedef struct packed {
    keys_s       kprev;
    func_e       func;
    mode_e       mode;
    disp_e       disp;
    disp_e       disp_save;
    logic [19:0] dly;
    logic        dly_en;
    logic [19:0] hold_cnt;
    logic        masking;
    logic        stop_out;
    logic [6:0]  tick;
    logic [9:0]  us;
    logic [11:0] held;
    logic [11:0] lamp_cnt;
    logic        lamp_on;
    logic        freqb;
    logic        avg_en;
    logic [6:0]  avg_n;
    logic [39:0] acc;
    logic [31:0] avg_res;
    logic        avg_ready;
    logic [31:0] last;
    logic [31:0] nulls;
    logic [7:0]  err;
    logic        standby;
    logic [15:0] idle;
    logic        gate;
    ind_s        ind;
    logic [31:0] dval;
    logic        a_wr;
    logic [3:0]  a_off;
    logic [31:0] rdata;
    logic        rdy;
  } st_s;

  st_s                s;
  st_s                n;
  logic [SYNC_W-1:0]  lv;
  keys_s              k;
  keys_s              pr;
  func_e              fsel;
  logic               batt;
  logic               fchg;
  logic               us_stb;
  logic               ms_stb;
  logic               dly_app;
  logic               avg_ok;
  logic [39:0]        sum;

  key_sync #(.W(SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({batt_save_pin, func_pin, key_pin}),
    .level   (lv)
  );

  assign k    = keys_s'(lv[7:0]);
  assign fsel = func_e'(lv[10:8]);
  assign batt = lv[11];

  function automatic logic [19:0] clampd(input logic [20:0] v);
    if (v < {1'b0, DLY_MIN_US}) begin
      return DLY_MIN_US;
    end else if (v > {1'b0, DLY_MAX_US}) begin
      return DLY_MAX_US;
    end
    return v[19:0];
  endfunction

  always_comb begin
    n       = s;
    pr      = k & ~s.kprev;
    n.kprev = k;
    fchg    = (fsel != s.func);
    n.func  = fsel;
    us_stb  = (s.tick == 7'(TICK_CYC - 1));
    ms_stb  = us_stb && (s.us == 10'(US_PER_MS - 1));
    n.tick  = us_stb ? 7'h00 : s.tick + 7'h01;
    n.us    = ms_stb ? 10'h000 : (us_stb ? s.us + 10'h001 : s.us);
    avg_ok  = (fsel == F_TI) || (fsel == F_PHASE) || (fsel == F_FREQA) ||
              (fsel == F_PERA) || (fsel == F_RATIO);
    sum     = s.acc + {8'h00, eng.reading};

    // delay edit, hold-off enable and channel B
    if (s.mode == M_EDIT) begin
      if (pr.up) begin
        n.dly = clampd({1'b0, s.dly} + {1'b0, DLY_STEP_US});
      end else if (pr.down) begin
        n.dly = clampd({1'b0, s.dly} - {1'b0, DLY_STEP_US});
      end
      if (pr.restart || pr.dly) begin
        n.mode = M_MEAS;
        n.disp = D_MEAS;
        if (pr.dly) begin
          n.dly_en = 1'b1;
        end
      end
    end else if (s.mode == M_MEAS) begin
      if ((pr.up || pr.down) && (fsel == F_TI || fsel == F_TOTAB)) begin
        n.mode = M_EDIT;
        n.disp = D_DELAY;
      end else if (pr.dly) begin
        if (s.freqb) begin
          n.freqb = 1'b0;
        end else if (fsel != F_FREQA) begin
          n.dly_en = ~s.dly_en;
        end
      end
      if (pr.restart) begin
        n.freqb = 1'b0;
      end
      if (pr.recall && fsel == F_CHECK) begin
        n.mode     = M_LAMP;
        n.lamp_cnt = 12'h000;
        n.lamp_on  = 1'b1;
      end
    end else begin
      if (ms_stb) begin
        n.lamp_cnt = s.lamp_cnt + 12'h001;
        if (s.lamp_cnt == 12'(LAMP_MS - 1)) begin
          n.lamp_cnt = 12'h000;
          n.lamp_on  = ~s.lamp_on;
        end
      end
      if (pr.restart || fsel != F_CHECK) begin
        n.mode = M_MEAS;
      end
    end

    // delay key held in frequency A selects channel B
    if (!k.dly || fsel != F_FREQA || s.freqb) begin
      n.held = 12'h000;
    end else if (ms_stb) begin
      n.held = s.held + 12'h001;
      if (s.held == 12'(HOLD_MS - 1)) begin
        n.freqb = 1'b1;
      end
    end
    if (fsel != F_FREQA) begin
      n.freqb = 1'b0;
    end

    // null recall and continue
    if (pr.rnull && s.disp != D_NULL) begin
      n.disp_save = n.disp;
      n.disp      = D_NULL;
    end else if (pr.restart && s.disp == D_NULL) begin
      n.disp = s.disp_save;
    end

    // stop-channel hold-off
    dly_app = s.dly_en && (s.func == F_TI || s.func == F_TOTAB);
    if (eng.start_trig && dly_app) begin
      n.hold_cnt = s.dly;
      n.masking  = 1'b1;
    end else if (s.masking && us_stb) begin
      n.hold_cnt = s.hold_cnt - 20'h00001;
      if (s.hold_cnt <= 20'h00001) begin
        n.masking = 1'b0;
      end
    end
    n.stop_out = eng.stop_trig && !(dly_app && s.masking);

    // hundred-reading sum, divided by ten
    if (pr.avg) begin
      n.avg_en = ~s.avg_en;
    end
    if (!avg_ok) begin
      n.avg_en = 1'b0;
    end
    n.gate = eng.done;
    if (eng.done) begin
      n.last = eng.reading;
    end
    if (pr.restart || pr.avg || fchg || !s.avg_en) begin
      n.avg_n = 7'h00;
      n.acc   = 40'h0;
      if (pr.restart || pr.avg || fchg) begin
        n.avg_ready = 1'b0;
      end
    end else if (eng.done) begin
      n.acc   = sum;
      n.avg_n = s.avg_n + 7'h01;
      if (s.avg_n == AVG_LAST) begin
        n.avg_res   = 32'(sum / AVG_DIV);
        n.avg_ready = 1'b1;
        n.avg_n     = 7'h00;
        n.acc       = 40'h0;
      end
    end

    // error codes: clears first so a new error in the same cycle wins
    if (fchg) begin
      n.err = ERR_NONE;
    end else begin
      if (eng.done && !eng.phase_unequal && s.err == ERR_PH_FREQ) begin
        n.err = ERR_NONE;
      end
      if (eng.done && !eng.range_err && !eng.overflow &&
          (s.err == ERR_RANGE || s.err == ERR_OVF)) begin
        n.err = ERR_NONE;
      end
      if (!eng.phase_fast && s.err == ERR_PH_FAST) begin
        n.err = ERR_NONE;
      end
      if (s.func == F_PHASE && eng.done && eng.phase_unequal) begin
        n.err = ERR_PH_FREQ;
      end
      if (s.func == F_PHASE && eng.phase_fast) begin
        n.err = ERR_PH_FAST;
      end
      if (eng.done && eng.range_err) begin
        n.err = ERR_RANGE;
      end
      if (eng.done && eng.overflow) begin
        n.err = ERR_OVF;
      end
      if (s.func == F_CHECK && eng.check_fail) begin
        n.err = ERR_SELFTEST;
      end
    end

    // battery save; the delay store is untouched by standby
    if (pr.stby) begin
      n.idle = 16'h0000;
      if (s.standby) begin
        n.standby = 1'b0;
      end else if (!batt) begin
        n.standby = 1'b1;
      end
    end else if (batt && !s.standby && ms_stb) begin
      n.idle = s.idle + 16'h0001;
      if (s.idle == 16'(IDLE_MS - 1)) begin
        n.standby = 1'b1;
        n.idle    = 16'h0000;
      end
    end

    // ahb-lite slave, zero wait states; write lands in the data phase
    n.rdy = 1'b1;
    n.a_wr = 1'b0;
    if (s.a_wr) begin
      case (s.a_off)
        REG_CTRL: begin
          n.dly_en = hwdata[0];
          n.avg_en = hwdata[1] && avg_ok;
        end
        REG_DELAY: n.dly   = clampd({1'b0, hwdata[19:0]});
        REG_NULL:  n.nulls = hwdata;
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      n.a_wr  = hwrite && (haddr[31:4] == 28'h0);
      n.a_off = haddr[3:0];
      n.rdata = 32'h0;
      if (!hwrite && haddr[31:4] == 28'h0) begin
        case (haddr[3:0])
          REG_CTRL:  n.rdata = {s.err, 13'h0, s.masking, s.standby, s.freqb, s.avg_ready,
                                s.mode, s.func, s.avg_en, s.dly_en};
          REG_DELAY: n.rdata = {12'h0, s.dly};
          REG_NULL:  n.rdata = s.nulls;
          REG_AVG:   n.rdata = s.avg_res;
          default:   n.rdata = 32'h0;
        endcase
      end
    end

    // indicators and display from next-state values
    n.ind.delay_led = n.freqb || (n.dly_en && fsel != F_FREQA);
    n.ind.avg_led   = n.avg_en;
    if (n.mode == M_LAMP) begin
      n.ind.delay_led = n.lamp_on;
      n.ind.avg_led   = n.lamp_on;
    end
    n.ind.gate_led  = n.gate;
    n.ind.lamp_on   = (n.mode == M_LAMP) && n.lamp_on;
    n.ind.lamp_test = (n.mode == M_LAMP);
    n.ind.chan_b    = n.freqb;
    n.ind.standby   = n.standby;
    case (n.disp)
      D_NULL:  n.dval = n.nulls;
      D_DELAY: n.dval = {12'h0, n.dly};
      default: n.dval = n.avg_en ? n.avg_res : n.last;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s     <= '0;
      s.dly <= DLY_RST_US;
      s.rdy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hrdata        = s.rdata;
  assign hreadyout     = s.rdy;
  assign hresp         = 1'b0;
  assign stop_trig_out = s.stop_out;
  assign ind           = s.ind;
  assign disp_src      = s.disp;
  assign disp_val      = s.dval;
  assign err_code      = s.err;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_dly_range;
    s.dly >= DLY_MIN_US && s.dly <= DLY_MAX_US;
  endproperty
  a_dly_range: assert property (p_dly_range) else $error("delay store out of range");

  property p_mask;
    s.masking && dly_app && eng.stop_trig |=> !stop_trig_out;
  endproperty
  a_mask: assert property (p_mask) else $error("stop passed during hold-off");

  property p_no_delay;
    !dly_app && eng.stop_trig |=> stop_trig_out;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("stop blocked outside hold-off");

  property p_avg_fn;
    s.avg_en |-> (s.func == F_TI || s.func == F_PHASE || s.func == F_FREQA ||
                  s.func == F_PERA || s.func == F_RATIO);
  endproperty
  a_avg_fn: assert property (p_avg_fn) else $error("averaging in illegal function");

  property p_avg_done;
    s.avg_en && eng.done && s.avg_n == AVG_LAST && !pr.restart && !pr.avg && !fchg
      |=> s.avg_ready && s.avg_n == 7'h00 ##1 ind.avg_led;
  endproperty
  a_avg_done: assert property (p_avg_done) else $error("average not finished at 100");

  property p_gate;
    eng.done |=> ind.gate_led;
  endproperty
  a_gate: assert property (p_gate) else $error("gate lamp missed a reading");

  property p_restart;
    s.mode == M_MEAS && pr.restart |=> s.avg_n == 7'h00 && s.acc == 40'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept partial average");

  property p_err01;
    !fchg && s.func == F_PHASE && eng.done && eng.phase_unequal && !eng.phase_fast &&
      !eng.range_err && !eng.overflow |=> err_code == ERR_PH_FREQ;
  endproperty
  a_err01: assert property (p_err01) else $error("code 01 not raised");

  property p_err_clr;
    fchg |=> err_code == ERR_NONE;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error kept over function change");

  property p_freqb;
    s.func != F_FREQA |-> !s.freqb;
  endproperty
  a_freqb: assert property (p_freqb) else $error("channel B outside frequency A");

  property p_dly_led;
    s.mode != M_LAMP |-> ind.delay_led == (s.freqb || (s.dly_en && s.func != F_FREQA));
  endproperty
  a_dly_led: assert property (p_dly_led) else $error("delay lamp disagrees with enable");

  c_freqb: cover property ($rose(s.freqb));
  c_avg:   cover property ($rose(s.avg_ready));
  c_lamp:  cover property (s.mode == M_LAMP ##1 s.mode == M_MEAS);
  c_edit:  cover property (s.mode == M_EDIT ##1 s.mode == M_MEAS && s.dly_en);
endmodule

/* test/panel_partner.sv */
// far-side model: operator keys, function switch and measurement engine
`timescale 1ns/1ps
module panel_partner
  import panel_pkg::*;
(
  // clock
  input  wire logic hclk,
  // panel pins and engine
  output keys_s      key_pin,
  output logic [2:0] func_pin,
  output logic       batt_save_pin,
  output eng_s       eng
);
  initial begin
    key_pin = '0;
    func_pin = 3'h0;
    batt_save_pin = 1'b0;
    eng = '0;
  end

  // hold a key long enough to pass the synchroniser, then let it settle
  task automatic press(input int b);
    key_pin[b] <= 1'b1;
    repeat (8) @(posedge hclk);
    key_pin[b] <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask

  // one-cycle completion strobe, flags {range, overflow, unequal} beside it
  task automatic done(input logic [31:0] r, input logic [2:0] f);
    eng.reading <= r;
    {eng.range_err, eng.overflow, eng.phase_unequal} <= f;
    eng.done <= 1'b1;
    @(posedge hclk);
    eng.done <= 1'b0;
    eng.reading <= ~r;
    {eng.range_err, eng.overflow, eng.phase_unequal} <= ~f;
    repeat (3) @(posedge hclk);
  endtask

  task automatic trig(input logic stop);
    if (stop) begin
      eng.stop_trig <= 1'b1;
    end else begin
      eng.start_trig <= 1'b1;
    end
    @(posedge hclk);
    eng.stop_trig <= 1'b0;
    eng.start_trig <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic level(input logic fast, input logic fail);
    eng.phase_fast <= fast;
    eng.check_fail <= fail;
    repeat (10) @(posedge hclk);
  endtask

  task automatic save(input logic b);
    batt_save_pin <= b;
    repeat (10) @(posedge hclk);
  endtask

  task automatic sel(input logic [2:0] f);
    func_pin <= f;
    repeat (10) @(posedge hclk);
  endtask
endmodule

/* test/tb.sv */
// self-checking bench for the counter front-panel control block
`timescale 1ns/1ps
module tb
  import panel_pkg::*;
;
  localparam int K_UP = 7;
  localparam int K_DN = 6;
  localparam int K_RST = 5;
  localparam int K_DLY = 4;
  localparam int K_AVG = 3;
  localparam int K_RECALL = 2;
  localparam int K_RNULL = 1;
  localparam int K_STBY = 0;

  typedef struct packed {logic [31:0] a; logic [31:0] w; logic [31:0] e;} row_s;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  keys_s       key_pin;
  logic [2:0]  func_pin;
  logic        batt_save_pin;
  eng_s        eng;
  logic        stop_trig_out;
  ind_s        ind;
  disp_e       disp_src;
  logic [31:0] disp_val;
  logic [7:0]  err_code;
  logic [31:0] rd;
  int          failures = 0;
  int          comparisons = 0;
  int          gate_cnt = 0;
  int          stop_cnt = 0;
  int          g;
  int          s;
  row_s        rows [9] = '{
    '{32'h4, 32'h64, 32'hc8}, '{32'h4, 32'hc7, 32'hc8}, '{32'h4, 32'hc8, 32'hc8},
    '{32'h4, 32'hc3501, 32'hc3500}, '{32'h4, 32'h2710, 32'h2710},
    '{32'h8, 32'h12345678, 32'h12345678}, '{32'h40, 32'h77, 32'h0},
    '{32'h0, 32'h3, 32'h3}, '{32'hc, 32'h55, 32'h0}};
  logic [2:0]  eflags [6] = '{3'h1, 3'h0, 3'h4, 3'h0, 3'h2, 3'h0};
  logic [7:0]  ecodes [6] = '{ERR_PH_FREQ, ERR_NONE, ERR_RANGE, ERR_NONE, ERR_OVF, ERR_NONE};

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (ind.gate_led === 1'b1) gate_cnt <= gate_cnt + 1;
    if (stop_trig_out === 1'b1) stop_cnt <= stop_cnt + 1;
  end

  counter_panel_control counter_panel_control_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .key_pin(key_pin), .func_pin(func_pin), .batt_save_pin(batt_save_pin), .eng(eng),
    .stop_trig_out(stop_trig_out), .ind(ind), .disp_src(disp_src), .disp_val(disp_val), .err_code(err_code));

  panel_partner panel_partner_inst (
    .hclk(hclk), .key_pin(key_pin), .func_pin(func_pin), .batt_save_pin(batt_save_pin), .eng(eng));

  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    comparisons++;
    if (v !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask

  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      failures++;
      wrap_up();
    end
  endtask

  // single word transfer; read data lands in rd at the closing edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("hreadyout", 1, hreadyout);
    chk("hresp", 0, hresp);
    chk("err_code", 0, err_code);
    ahb(0, 32'h4, 0);
    chk("delay reset", DLY_RST_US, rd);
    for (int i = 0; i < 9; i++) begin
      ahb(1, rows[i].a, rows[i].w);
      ahb(0, rows[i].a, 0);
      chk("register", rows[i].e, rd);
    end
    panel_partner_inst.sel(F_TOTA);
    panel_partner_inst.press(K_AVG);
    chk("avg led tota", 0, ind.avg_led);
    panel_partner_inst.sel(F_FREQA);
    chk("no delay in freq", 0, ind.delay_led);
    chk("chan b off", 0, ind.chan_b);
    panel_partner_inst.press(K_AVG);
    chk("avg led on", 1, ind.avg_led);
    repeat (30) panel_partner_inst.done(32'h3e8, 3'h0);
    panel_partner_inst.press(K_RST);
    g = gate_cnt;
    repeat (100) panel_partner_inst.done(32'h7, 3'h0);
    repeat (4) @(posedge hclk);
    chk("gate flashes", 100, gate_cnt - g);
    ahb(0, 32'hc, 0);
    chk("average", 32'h46, rd);
    ahb(0, 32'h0, 0);
    chk("avg ready", 1, rd[7]);
    panel_partner_inst.press(K_AVG);
    chk("avg led off", 0, ind.avg_led);
    panel_partner_inst.sel(F_TI);
    panel_partner_inst.press(K_UP);
    chk("edit disp", D_DELAY, disp_src);
    panel_partner_inst.press(K_UP);
    chk("edit value", 32'h2774, disp_val);
    panel_partner_inst.press(K_UP);
    panel_partner_inst.press(K_DN);
    chk("step down", 32'h2774, disp_val);
    panel_partner_inst.press(K_DLY);
    chk("commit disp", D_MEAS, disp_src);
    chk("dly led commit", 1, ind.delay_led);
    ahb(0, 32'h4, 0);
    chk("stored delay", 32'h2774, rd);
    panel_partner_inst.press(K_DLY);
    chk("dly led off", 0, ind.delay_led);
    panel_partner_inst.press(K_DLY);
    chk("dly led on", 1, ind.delay_led);
    ahb(1, 32'h4, 32'hc8);
    s = stop_cnt;
    panel_partner_inst.trig(0);
    repeat (19700) @(posedge hclk);
    panel_partner_inst.trig(1);
    chk("masked stop", s, stop_cnt);
    repeat (500) @(posedge hclk);
    panel_partner_inst.trig(1);
    chk("late stop", s + 1, stop_cnt);
    panel_partner_inst.sel(F_PERA);
    panel_partner_inst.trig(0);
    panel_partner_inst.trig(1);
    chk("no holdoff", s + 2, stop_cnt);
    panel_partner_inst.press(K_STBY);
    chk("standby", 1, ind.standby);
    ahb(0, 32'h4, 0);
    chk("delay in standby", 32'hc8, rd);
    panel_partner_inst.press(K_STBY);
    chk("wake", 0, ind.standby);
    ahb(0, 32'h4, 0);
    chk("delay after standby", 32'hc8, rd);
    panel_partner_inst.save(1'b1);
    panel_partner_inst.press(K_STBY);
    chk("save grant", 0, ind.standby);
    panel_partner_inst.save(1'b0);
    panel_partner_inst.press(K_RNULL);
    chk("null disp", D_NULL, disp_src);
    chk("null value", 32'h12345678, disp_val);
    panel_partner_inst.press(K_RST);
    chk("continue", D_MEAS, disp_src);
    panel_partner_inst.sel(F_PHASE);
    for (int i = 0; i < 6; i++) begin
      panel_partner_inst.done(32'h5, eflags[i]);
      chk("err seq", ecodes[i], err_code);
    end
    panel_partner_inst.done(32'h5, 3'h2);
    panel_partner_inst.sel(F_PERA);
    chk("err func change", ERR_NONE, err_code);
    panel_partner_inst.sel(F_PHASE);
    panel_partner_inst.level(1'b1, 1'b0);
    chk("err fast", ERR_PH_FAST, err_code);
    panel_partner_inst.level(1'b0, 1'b0);
    chk("err fast clear", ERR_NONE, err_code);
    panel_partner_inst.sel(F_CHECK);
    panel_partner_inst.level(1'b0, 1'b1);
    chk("err selftest", ERR_SELFTEST, err_code);
    panel_partner_inst.level(1'b0, 1'b0);
    panel_partner_inst.press(K_RECALL);
    chk("lamp test on", 1, ind.lamp_test);
    chk("lamp phase", 1, ind.lamp_on);
    panel_partner_inst.press(K_RST);
    chk("lamp test off", 0, ind.lamp_test);
    wrap_up();
  end
endmodule
